// File: hdl/ccr_core_config.sv
// core feature configuration register, coprocessor-0 register 16 select 3
//
// Behaviour
// - bit 31 always reads one: a further configuration register exists
// - bits 30-23, 9, 7 and 2-1 always read zero
// - priority level width field, bits 22-21, reads 01 (eight-bit fields)
// - compact set revision, bits 20-18, reads 000 (first release)
// - bit 17 reads one: application-specific extension present
// - bit 16 read/write: instruction set used on exception entry
// - bits 15-14 read-only: 11 compact after reset, 10 standard after reset
// - exception-entry bit and availability field loaded from boot fuse
// - bit 13 reads one: user-local register present
// - bit 12 reads one: read/execute inhibit enables present
// - bit 11 reads one: signal-processing extension revision 2 present
// - bit 10 reads one: signal-processing extension present
// - bit 8 reads one: flow trace hardware present
// - bit 6 reads one: external vector controller support present
// - bit 5 reads one: vectored interrupts present
// - bit 4 reads zero: 4 KB minimum page size
// - bit 3 reads one: common device map present
// - bit 0 reads zero: no trace logic
// - reached by coprocessor-0 moves at register 16, select 3
`timescale 1ns/10ps
`include "ccr_defs.svh"
module ccr_core_config
  import ccr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [4:0]  cp0_reg_num,
  input  wire logic [2:0]  cp0_sel,
  input  wire logic        cp0_rd_en,
  input  wire logic        cp0_wr_en,
  input  wire logic [31:0] cp0_wr_data,
  output logic      [31:0] cp0_rd_data,
  output logic             cp0_rd_valid,
  input  wire logic        boot_instr_set_fuse,
  output logic             exception_entry_instr_set,
  output logic      [1:0]  instr_set_availability,
  output logic             config_ready
);
  import ccr_pkg::*;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  ccr_if link ();

  ccr_decode u_decode
  (
    .cp0_reg_num (cp0_reg_num),
    .cp0_sel     (cp0_sel),
    .cp0_rd_en   (cp0_rd_en),
    .cp0_wr_en   (cp0_wr_en),
    .bus         (link.dec)
  );

  ccr_fuse u_fuse
  (
    .clk                 (clk),
    .arst_n              (arst_n),
    .boot_instr_set_fuse (boot_instr_set_fuse),
    .bus                 (link.fus)
  );

  // ----------------------------------------
  // writable and fuse-seeded state
  // ----------------------------------------
  logic       exc_isa_r;
  logic       exc_isa_nxt;
  logic [1:0] avail_r;
  logic [1:0] avail_nxt;
  wire logic  wr_take;

  // writes before the fuse lands are dropped so the strap value cannot be lost
  assign wr_take     = link.wr_hit & link.fuse_ready;
  assign exc_isa_nxt = link.fuse_load ? link.fuse_value :
                       wr_take ? cp0_wr_data[`CCR_EXC_ISA_BIT] : exc_isa_r;
  assign avail_nxt   = link.fuse_load ? {`CCR_AVAIL_BOTH, link.fuse_value} : avail_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      exc_isa_r <= `CCR_EXC_ISA_RST;
      avail_r   <= `CCR_AVAIL_RST;
    end
    else
    begin
      exc_isa_r <= exc_isa_nxt;
      avail_r   <= avail_nxt;
    end
  end

  // ----------------------------------------
  // read word assembly
  // ----------------------------------------
  logic [31:0] dyn_word;
  logic [31:0] word;
  localparam logic [31:0] FIXED_VALUE = `CCR_FIXED_VALUE;
  localparam logic [31:0] DYN_MASK    = `CCR_DYN_MASK;

  // ----------------------------------------
  // fixed fields, one line per reported feature
  // ----------------------------------------
  wire logic [31:0] fixed_word;

  assign fixed_word[31]    = FIXED_VALUE[31];
  assign fixed_word[30:23] = FIXED_VALUE[30:23];
  assign fixed_word[22:21] = `CCR_PRIO_W_VALUE;
  assign fixed_word[20:18] = `CCR_COMPACT_REV_VAL;
  assign fixed_word[17]    = FIXED_VALUE[17];
  assign fixed_word[16:14] = FIXED_VALUE[16:14];    // masked off below, state bits
  assign fixed_word[13]    = FIXED_VALUE[13];
  assign fixed_word[12]    = FIXED_VALUE[12];
  assign fixed_word[11]    = FIXED_VALUE[11];
  assign fixed_word[10]    = FIXED_VALUE[10];
  assign fixed_word[9]     = FIXED_VALUE[9];
  assign fixed_word[8]     = FIXED_VALUE[8];
  assign fixed_word[7]     = FIXED_VALUE[7];
  assign fixed_word[6]     = FIXED_VALUE[6];
  assign fixed_word[5]     = FIXED_VALUE[5];
  assign fixed_word[4]     = FIXED_VALUE[4];
  assign fixed_word[3]     = FIXED_VALUE[3];
  assign fixed_word[2:1]   = FIXED_VALUE[2:1];
  assign fixed_word[0]     = FIXED_VALUE[0];

  // only bits 16-14 come from state; every other bit is a constant,
  // so any write to them has nothing to land in
  assign dyn_word = {15'h0000, exc_isa_r, avail_r, 14'h0000};

  genvar gi;
  generate
    for (gi = 0; gi < `CCR_WORD_W; gi++)
    begin : g_bit
      // per-bit mux: writes never reach a constant bit
      assign word[gi] = DYN_MASK[gi] ? dyn_word[gi] : fixed_word[gi];
    end
  endgenerate

  // ----------------------------------------
  // read port, one cycle after the strobe
  // ----------------------------------------
  logic [31:0] rd_data_r;
  logic [31:0] rd_data_nxt;
  logic        rd_valid_r;

  assign rd_data_nxt = link.rd_hit ? word : `CCR_RD_DATA_RST;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_r  <= `CCR_RD_DATA_RST;
      rd_valid_r <= 1'h0;
    end
    else
    begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= link.rd_hit;
    end
  end

  assign cp0_rd_data               = rd_data_r;
  assign cp0_rd_valid              = rd_valid_r;
  assign exception_entry_instr_set = exc_isa_r;
  assign instr_set_availability    = avail_r;
  assign config_ready              = link.fuse_ready;

endmodule : ccr_core_config

// File: hdl/ccr_decode.sv
// coprocessor-0 access decode for the configuration register
`timescale 1ns/10ps
module ccr_decode
  import ccr_pkg::*;
(
  input  wire logic [4:0] cp0_reg_num,
  input  wire logic [2:0] cp0_sel,
  input  wire logic       cp0_rd_en,
  input  wire logic       cp0_wr_en,
  ccr_if.dec              bus
);
  import ccr_pkg::*;

  // ----------------------------------------
  // strobes qualified by location
  // ----------------------------------------
  wire logic rd_loc;
  wire logic wr_loc;

  assign rd_loc     = ccr_hit(cp0_reg_num, cp0_sel);
  assign wr_loc     = ccr_hit(cp0_reg_num, cp0_sel);
  assign bus.rd_hit = cp0_rd_en & rd_loc;
  assign bus.wr_hit = cp0_wr_en & wr_loc;

endmodule : ccr_decode

// File: hdl/ccr_defs.svh
// constants for the core feature configuration register
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// ----------------------------------------
// coprocessor-0 location
// ----------------------------------------
`define CCR_CP0_REG_NUM      5'h10
`define CCR_CP0_SEL          3'h3

// ----------------------------------------
// word layout
// ----------------------------------------
`define CCR_WORD_W           32
`define CCR_FIXED_VALUE      32'h80223D68
`define CCR_DYN_MASK         32'h0001C000
`define CCR_EXC_ISA_BIT      16
`define CCR_AVAIL_LSB        14
`define CCR_AVAIL_MSB        15
`define CCR_NEXT_CFG_BIT     31
`define CCR_PRIO_W_LSB       21
`define CCR_PRIO_W_VALUE     2'h1
`define CCR_COMPACT_REV_LSB  18
`define CCR_COMPACT_REV_VAL  3'h0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCR_EXC_ISA_RST      1'h0
`define CCR_AVAIL_RST        2'h2
`define CCR_AVAIL_BOTH       1'h1
`define CCR_RD_DATA_RST      32'h00000000

`endif

// File: hdl/ccr_fuse.sv
// boot instruction-set fuse capture after reset release
`timescale 1ns/10ps
module ccr_fuse
  import ccr_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic boot_instr_set_fuse,
  ccr_if.fus        bus
);
  import ccr_pkg::*;

  // ----------------------------------------
  // sequence: hold one edge so the strap settles, then sample
  // ----------------------------------------
  ccr_state_t state_r;
  ccr_state_t state_nxt;
  wire logic  sample;

  always_comb
  begin
    case (state_r)
      CCR_ST_HOLD:    state_nxt = CCR_ST_CAPTURE;
      CCR_ST_CAPTURE: state_nxt = CCR_ST_READY;
      CCR_ST_READY:   state_nxt = CCR_ST_READY;
      default:        state_nxt = CCR_ST_HOLD;
    endcase
  end

  assign sample = (state_r == CCR_ST_CAPTURE);

  // strap is taken by a clocked edge, never by the reset itself
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= CCR_ST_HOLD;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // the core register latches the strap on the load edge, so no copy here
  assign bus.fuse_load  = sample;
  assign bus.fuse_value = boot_instr_set_fuse;
  assign bus.fuse_ready = (state_r == CCR_ST_READY);

endmodule : ccr_fuse

// File: hdl/ccr_if.sv
// internal carrier between decode, fuse capture and the register core
`timescale 1ns/10ps
interface ccr_if;
  logic rd_hit;
  logic wr_hit;
  logic fuse_load;
  logic fuse_value;
  logic fuse_ready;

  modport dec
  (
    output rd_hit,
    output wr_hit
  );

  modport fus
  (
    output fuse_load,
    output fuse_value,
    output fuse_ready
  );

  modport core
  (
    input rd_hit,
    input wr_hit,
    input fuse_load,
    input fuse_value,
    input fuse_ready
  );
endinterface : ccr_if

// File: hdl/ccr_pkg.sv
// types and shared decoding for the core feature configuration register
`include "ccr_defs.svh"
package ccr_pkg;

  // ----------------------------------------
  // fuse capture sequence
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    CCR_ST_HOLD    = 2'b00,
    CCR_ST_CAPTURE = 2'b01,
    CCR_ST_READY   = 2'b11
  } ccr_state_t;

  // ----------------------------------------
  // location decode, shared by read and write paths
  // ----------------------------------------
  function automatic logic ccr_hit
  (
    input logic [4:0] reg_num,
    input logic [2:0] sel
  );
    ccr_hit = (reg_num == `CCR_CP0_REG_NUM) && (sel == `CCR_CP0_SEL);
  endfunction : ccr_hit

endpackage : ccr_pkg

// File: tb/ccr_checker.sv
// assertions on the ports of the configuration register
`timescale 1ns/10ps
`include "ccr_defs.svh"
module ccr_checker
  import ccr_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [4:0]  cp0_reg_num,
  input wire logic [2:0]  cp0_sel,
  input wire logic        cp0_rd_en,
  input wire logic        cp0_wr_en,
  input wire logic [31:0] cp0_wr_data,
  input wire logic [31:0] cp0_rd_data,
  input wire logic        cp0_rd_valid,
  input wire logic        boot_instr_set_fuse,
  input wire logic        exception_entry_instr_set,
  input wire logic [1:0]  instr_set_availability,
  input wire logic        config_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  localparam logic [31:0] FIXED = `CCR_FIXED_VALUE;
  wire hit = cp0_reg_num == `CCR_CP0_REG_NUM && cp0_sel == `CCR_CP0_SEL;
  wire wr_ok = cp0_wr_en && hit && config_ready;
  // ----------------------------------------
  // fuse capture steps
  // ----------------------------------------
  sequence s_release;
    $rose(arst_n);
  endsequence
  sequence s_capture;
    !config_ready ##2 config_ready;
  endsequence
  a_ready_timing: assert property (s_release |-> s_capture) else $error("ready late");
  a_fuse_load: assert property (
    $rose(config_ready) |-> exception_entry_instr_set == $past(boot_instr_set_fuse)
    && instr_set_availability == {1'b1, $past(boot_instr_set_fuse)}) else $error("fuse load");
  a_avail_fixed: assert property (
    config_ready && $past(config_ready) |-> $stable(instr_set_availability)) else $error("avail moved");
  a_read_answer: assert property (cp0_rd_en && hit |=> cp0_rd_valid) else $error("no answer");
  a_miss_silent: assert property (
    !(cp0_rd_en && hit) |=> !cp0_rd_valid && cp0_rd_data == 32'h0) else $error("stray read");
  a_fixed_upper: assert property (
    cp0_rd_valid |-> cp0_rd_data[31:17] == FIXED[31:17]) else $error("fixed upper bits");
  a_fixed_lower: assert property (
    cp0_rd_valid |-> cp0_rd_data[13:0] == FIXED[13:0]) else $error("fixed lower bits");
  a_dyn_bits: assert property (
    cp0_rd_valid |-> cp0_rd_data[16:14] == $past({exception_entry_instr_set, instr_set_availability}))
    else $error("dyn bits");
  a_write_take: assert property (
    wr_ok |=> exception_entry_instr_set == $past(cp0_wr_data[16])) else $error("write lost");
  a_write_hold: assert property (
    config_ready && !wr_ok |=> $stable(exception_entry_instr_set)) else $error("bit moved");
endmodule : ccr_checker

bind ccr_core_config ccr_checker chk_u (.clk(clk), .arst_n(arst_n), .cp0_reg_num(cp0_reg_num),
  .cp0_sel(cp0_sel), .cp0_rd_en(cp0_rd_en), .cp0_wr_en(cp0_wr_en), .cp0_wr_data(cp0_wr_data),
  .cp0_rd_data(cp0_rd_data), .cp0_rd_valid(cp0_rd_valid), .boot_instr_set_fuse(boot_instr_set_fuse),
  .exception_entry_instr_set(exception_entry_instr_set), .instr_set_availability(instr_set_availability),
  .config_ready(config_ready));

// File: tb/ccr_core_config_bench.sv
// self-checking bench for the configuration register
`timescale 1ns/10ps
`include "ccr_defs.svh"
module ccr_core_config_bench;
  import ccr_pkg::*;
  logic        clk = 0, arst_n = 0, rd_en = 0, wr_en = 0, fuse = 0, fz = 0, exp_exc = 0;
  logic [4:0]  reg_num = 0;
  logic [2:0]  sel = 0;
  logic [31:0] wr_data = 0, seed = 32'hDEF4, rd_data;
  logic        rd_valid, exc, ready;
  logic [1:0]  avail;
  logic [31:0] corner [4] = '{32'hFFFFFFFF, 32'hFFFEFFFF, 32'h00010000, 32'h00000000};
  int          err_total = 0, comparisons = 0, cycles = 0;

  initial forever #50 clk = ~clk;

  ccr_core_config dut_u (.clk(clk), .arst_n(arst_n), .cp0_reg_num(reg_num), .cp0_sel(sel),
    .cp0_rd_en(rd_en), .cp0_wr_en(wr_en), .cp0_wr_data(wr_data), .cp0_rd_data(rd_data),
    .cp0_rd_valid(rd_valid), .boot_instr_set_fuse(fuse), .exception_entry_instr_set(exc),
    .instr_set_availability(avail), .config_ready(ready));

  function automatic logic [31:0] rnd(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : rnd

  function automatic logic [31:0] word(input logic e, input logic f);
    return `CCR_FIXED_VALUE | {15'h0, e, 1'b1, f, 14'h0};
  endfunction : word

  task automatic complete_run;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // ----------------------------------------
  // one access, modelled and compared
  // ----------------------------------------
  task automatic step(input logic r, input logic w, input logic [4:0] rn, input logic [2:0] s,
                      input logic [31:0] d);
    logic [31:0] exp_d;
    rd_en = r;
    wr_en = w;
    reg_num = rn;
    sel = s;
    wr_data = d;
    exp_d = (r && rn == 5'h10 && s == 3'h3) ? word(exp_exc, fz) : 32'h0;
    if (w && rn == 5'h10 && s == 3'h3)
      exp_exc = d[16];
    @(negedge clk);
    check(rd_data & 32'hFFFE0000, exp_d & 32'hFFFE0000);
    check(rd_data & 32'h0001C000, exp_d & 32'h0001C000);
    check(rd_data & 32'h00003C00, exp_d & 32'h00003C00);
    check(rd_data & 32'h000003FF, exp_d & 32'h000003FF);
    check({31'h0, rd_valid}, {31'h0, exp_d != 32'h0});
    check({29'h0, exc, avail}, {29'h0, exp_exc, 1'b1, fz});
  endtask : step

  task automatic do_reset(input logic f);
    arst_n = 0;
    fuse = f;
    fz = f;
    exp_exc = f;
    repeat (20) @(negedge clk);
    check({28'h0, ready, exc, avail}, 32'h2);
    arst_n = 1;
    repeat (3) @(negedge clk);
    check({28'h0, ready, exc, avail}, {28'h0, 1'b1, f, 1'b1, f});
  endtask : do_reset

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      complete_run();
    end
  end

  // ----------------------------------------
  // main sequence: three resets, fuse 0 then 1, the last from seed[5]
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 3; i++)
    begin
      do_reset(i == 2 ? seed[5] : i[0]);
      foreach (corner[k])
      begin
        step(1'b1, 1'b1, 5'h10, 3'h3, corner[k]);
        step(1'b1, 1'b0, 5'h10, 3'h3, 32'h0);
      end
      repeat (300)
      begin
        seed = rnd(seed);
        // near misses on number or select are common on purpose
        fuse = seed[2];
        step(seed[0], seed[1], seed[3] ? 5'h10 : seed[8:4], seed[9] ? 3'h3 : seed[12:10],
             rnd(seed ^ 32'h5A5A));
      end
      rd_en = 0;
      wr_en = 0;
    end
    complete_run();
  end
endmodule : ccr_core_config_bench
